// ===== common/scfdc_params.svh
// Named offsets, bit positions, reset values and counts of the sinc block
`ifndef SCFDC_PARAMS_SVH
`define SCFDC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (word addresses on the plain register port)
// ----------------------------------------------------------------
`define SCFDC_ADDR_CTRL   8'h11
`define SCFDC_ADDR_OUT4   8'h13
`define SCFDC_ADDR_OUT5   8'h14
`define SCFDC_ADDR_STAT   8'h18
`define SCFDC_ADDR_MASK   8'h19

// ----------------------------------------------------------------
// Control register field positions
// ----------------------------------------------------------------
`define SCFDC_FLAG4       4
`define SCFDC_FLAG5       5
`define SCFDC_OSR_LO      6
`define SCFDC_OSR_HI      7
`define SCFDC_DECODER0_ENABLE        8
`define SCFDC_IRQEN       14

// ----------------------------------------------------------------
// Status and mask bits, reset values
// ----------------------------------------------------------------
`define SCFDC_ST_SAMPLE   0
`define SCFDC_ST_OVRUN    1
`define SCFDC_ST_W        2
`define SCFDC_WORD_RST    16'h0000
`define SCFDC_ST_RST      2'h0

// ----------------------------------------------------------------
// Core identity on the register port
// ----------------------------------------------------------------
`define SCFDC_CORE_SUPV   1'b0

// ----------------------------------------------------------------
// Decoder timing in clocks, filter sizing
// ----------------------------------------------------------------
`define SCFDC_BLANK       4'h6
`define SCFDC_LOSS        4'hC
`define SCFDC_ACC_W       25
`define SCFDC_BASE_LEN    9'h020
`define SCFDC_ONE9        9'h001

`endif

// ===== common/scfdc_pkg.sv
// Types shared by the sinc decoder and filter modules
package scfdc_pkg;

	// Oversampling rate codes
	typedef enum logic [1:0] {
		OSR_32  = 2'h0,
		OSR_64  = 2'h1,
		OSR_128 = 2'h2,
		OSR_256 = 2'h3
	} scfdc_osr_t;

	// Manchester decoder states, one-hot
	typedef enum logic [2:0] {
		DEC_OFF  = 3'h1,
		DEC_HUNT = 3'h2,
		DEC_LOCK = 3'h4
	} scfdc_dec_t;

	// Register data word
	typedef logic [15:0] scfdc_word_t;

endpackage

// ===== common/scfdc_stream_if.sv
// Bit stream into one sinc filter and its decimated samples out
`timescale 1ns/1ns
interface scfdc_stream_if;
	logic                    enable;       // Filter runs while high
	scfdc_pkg::scfdc_osr_t   oversampling_select;          // Common oversampling rate
	logic                    bit_valid;    // One decoded bit this cycle
	logic                    bit_val;      // Value of that bit
	logic                    sample_valid; // One-cycle new-sample pulse
	scfdc_pkg::scfdc_word_t  sample;       // Decimated sample

	// Decoder side
	modport src (
		output enable,
		output oversampling_select,
		output bit_valid,
		output bit_val,
		input  sample_valid,
		input  sample
	);

	// Filter side
	modport flt (
		input  enable,
		input  oversampling_select,
		input  bit_valid,
		input  bit_val,
		output sample_valid,
		output sample
	);
endinterface

// ===== src/scfdc_filter.sv
// Cubic sinc decimation filter for one decoded bit stream
`timescale 1ns/1ns
`include "scfdc_params.svh"
module scfdc_filter (
	input  wire logic  mclk,
	input  wire logic  nrst,
	scfdc_stream_if.flt st
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [`SCFDC_ACC_W-1:0] i1_q, i2_q, i3_q;   // Integrators
	logic [`SCFDC_ACC_W-1:0] d1_q, d2_q, d3_q;   // Comb delays
	logic [`SCFDC_ACC_W-1:0] c1, c2, c3;         // Comb outputs
	logic [7:0]              cnt_q;              // Bits in this frame
	logic [7:0]              last;               // Final bit index
	logic                    dec_now;            // Decimation instant
	logic                    valid_q;            // Sample pulse
	scfdc_pkg::scfdc_word_t  sample_q;           // Sample held
	scfdc_pkg::scfdc_word_t  scaled;             // Comb result scaled

	// Frame length minus one, from the common rate
	assign last = 8'((`SCFDC_BASE_LEN << st.oversampling_select) - `SCFDC_ONE9);
	assign dec_now = st.bit_valid && (cnt_q == last);

	// Comb section and scaling to sixteen bits
	always_comb begin
		c1 = i3_q - d1_q;
		c2 = c1 - d2_q;
		c3 = c2 - d3_q;
		unique case (st.oversampling_select)
			scfdc_pkg::OSR_32:  scaled = c3[15:0];
			scfdc_pkg::OSR_64:  scaled = c3[18:3];
			scfdc_pkg::OSR_128: scaled = c3[21:6];
			scfdc_pkg::OSR_256: scaled = c3[24:9];
		endcase
	end

	// Integrators advance once per decoded bit
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			i1_q <= '0;
			i2_q <= '0;
			i3_q <= '0;
		end else if (!st.enable) begin
			i1_q <= '0;
			i2_q <= '0;
			i3_q <= '0;
		end else if (st.bit_valid) begin
			i1_q <= i1_q + `SCFDC_ACC_W'(st.bit_val);
			i2_q <= i2_q + i1_q;
			i3_q <= i3_q + i2_q;
		end
	end

	// Bit counter and comb delays, one sample per frame
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			d1_q  <= '0;
			d2_q  <= '0;
			d3_q  <= '0;
		end else if (!st.enable) begin
			cnt_q <= '0;
			d1_q  <= '0;
			d2_q  <= '0;
			d3_q  <= '0;
		end else if (dec_now) begin // RQ10
			cnt_q <= '0;
			d1_q  <= i3_q;
			d2_q  <= c1;
			d3_q  <= c2;
		end else if (st.bit_valid) begin
			cnt_q <= cnt_q + 8'h01;
		end
	end

	// Output sample and its pulse
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			valid_q  <= 1'b0;
			sample_q <= `SCFDC_WORD_RST;
		end else begin
			valid_q <= st.enable && dec_now; // RQ10
			if (st.enable && dec_now)
				sample_q <= scaled;
		end
	end

	assign st.sample_valid = valid_q;
	assign st.sample       = sample_q;

endmodule

// ===== src/scfdc_top.sv
// Decoder 0 with its filter pair, control register and interrupt
`timescale 1ns/1ns
`include "scfdc_params.svh"

// Summary of operation
// (RQ1) Reading output 5 clears ready flag 5
// (RQ2) Flags 4 and 5 set in one cycle
// (RQ3) Interrupt only with pair enable, unmasked
// (RQ4) Two-bit field picks rate 32 to 256
// (RQ5) Rate writes taken only with decoders off
// (RQ6) Enable bit turns decoder and filters on
// (RQ7) Enabled decoder forces pin single or differential
// (RQ8) Only supervisory core writes decoder enable
// (RQ9) New sample in output sets ready flag
// (RQ10) One sample per rate count of bits
module scfdc_top (
	input  wire logic                   mclk,
	input  wire logic                   nrst,
	input  wire logic [7:0]             reg_addr,
	input  wire scfdc_pkg::scfdc_word_t reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic                   reg_core,
	output wire scfdc_pkg::scfdc_word_t reg_rdata,
	input  wire logic                   md0_pos_pin,
	input  wire logic                   md0_neg_pin,
	input  wire logic                   pin_output_mode_bit,
	output wire logic                   md0_input_forced,
	output wire logic                   md0_diff_mode,
	output wire logic                   irq
);

	// ------------------------------------------------------------
	// Control and status state
	// ------------------------------------------------------------
	scfdc_pkg::scfdc_osr_t  osr_q;        // Common rate field
	logic                   md0_en_q;     // Decoder 0 enable
	logic                   irq_en_q;     // Pair 4/5 interrupt enable
	logic                   flag4_q;      // Sample ready 4
	logic                   flag5_q;      // Sample ready 5
	logic [`SCFDC_ST_W-1:0] stat_q;       // Sticky event bits
	logic [`SCFDC_ST_W-1:0] mask_q;       // Event mask
	logic [`SCFDC_ST_W-1:0] stat_set;     // Events this cycle
	logic [`SCFDC_ST_W-1:0] stat_clr;     // Write-one clears
	logic                   irq_q;        // Interrupt level
	scfdc_pkg::scfdc_word_t rdata_q;      // Read data, one cycle
	scfdc_pkg::scfdc_word_t rd_mux;       // Read data selected
	scfdc_pkg::scfdc_word_t ctrl_rd;      // Control word as read

	// ------------------------------------------------------------
	// Filter outputs
	// ------------------------------------------------------------
	scfdc_pkg::scfdc_word_t hold4_q;      // Sample 4 awaiting pair
	scfdc_pkg::scfdc_word_t out4_q;       // Output register 4
	scfdc_pkg::scfdc_word_t out5_q;       // Output register 5
	logic                   pair_set;     // Both samples complete

	// ------------------------------------------------------------
	// Decoder state
	// ------------------------------------------------------------
	logic                   pos_s1_q;     // Positive pin, stage 1
	logic                   pos_s2_q;     // Positive pin, stage 2
	logic                   neg_s1_q;     // Negative pin, stage 1
	logic                   neg_s2_q;     // Negative pin, stage 2
	logic                   line_now;     // Line level this cycle
	logic                   line_q;       // Line level last cycle
	logic                   edge_seen;    // Line changed
	logic                   forced_q;     // Pin mode forced
	logic                   diff_q;       // Differential in force
	scfdc_pkg::scfdc_dec_t  dec_q;        // Decoder state
	logic [3:0]             tm_q;         // Clocks since last accepted edge
	logic                   bit_stb_q;    // Decoded bit strobe
	logic                   bit_val_q;    // Decoded bit value
	logic                   bit_ch_q;     // Channel of that bit
	logic                   ch_q;         // Channel of next bit

	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------
	logic wr_supv;                        // Write from supervisor
	logic wr_ctrl;                        // Supervisor control write
	logic rd_out4;                        // Read of output 4
	logic rd_out5;                        // Read of output 5
	logic wr_stat;                        // Status clear write
	logic wr_mask;                        // Mask write

	assign wr_supv = reg_wr && (reg_core == `SCFDC_CORE_SUPV);
	assign wr_ctrl = wr_supv && (reg_addr == `SCFDC_ADDR_CTRL);
	assign rd_out4 = reg_rd && (reg_addr == `SCFDC_ADDR_OUT4);
	assign rd_out5 = reg_rd && (reg_addr == `SCFDC_ADDR_OUT5);
	assign wr_stat = reg_wr && (reg_addr == `SCFDC_ADDR_STAT);
	assign wr_mask = reg_wr && (reg_addr == `SCFDC_ADDR_MASK);

	// ------------------------------------------------------------
	// Filter links
	// ------------------------------------------------------------
	scfdc_stream_if s4 ();                // Even bits, filter 4
	scfdc_stream_if s5 ();                // Odd bits, filter 5

	// Filters run only while the decoder is enabled
	assign s4.enable    = md0_en_q; // RQ6
	assign s5.enable    = md0_en_q; // RQ6
	assign s4.oversampling_select       = osr_q; // RQ4
	assign s5.oversampling_select       = osr_q; // RQ4
	assign s4.bit_valid = bit_stb_q && !bit_ch_q;
	assign s5.bit_valid = bit_stb_q && bit_ch_q;
	assign s4.bit_val   = bit_val_q;
	assign s5.bit_val   = bit_val_q;

	scfdc_filter u_flt4 (
		.mclk (mclk),
		.nrst (nrst),
		.st   (s4.flt)
	);

	scfdc_filter u_flt5 (
		.mclk (mclk),
		.nrst (nrst),
		.st   (s5.flt)
	);

	// Filter 5 finishes one bit after filter 4, so its pulse
	// marks the moment both samples of a pair are complete
	assign pair_set = s5.sample_valid;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Two stages per pin before any decoding
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pos_s1_q <= 1'b0;
			pos_s2_q <= 1'b0;
			neg_s1_q <= 1'b0;
			neg_s2_q <= 1'b0;
		end else begin
			pos_s1_q <= md0_pos_pin;
			pos_s2_q <= pos_s1_q;
			neg_s1_q <= md0_neg_pin;
			neg_s2_q <= neg_s1_q;
		end
	end

	// ------------------------------------------------------------
	// Forced input mode
	// ------------------------------------------------------------
	// Mode follows the pin mode bit only while enabled
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			forced_q <= 1'b0;
			diff_q   <= 1'b0;
		end else begin
			forced_q <= md0_en_q; // RQ7
			diff_q   <= md0_en_q && pin_output_mode_bit; // RQ7
		end
	end

	// Differential reads the pin pair, single-ended the pin
	assign line_now  = diff_q ? (pos_s2_q && !neg_s2_q) : pos_s2_q;
	assign edge_seen = line_now != line_q;

	// ------------------------------------------------------------
	// Manchester decoder
	// ------------------------------------------------------------
	// State: off, hunting for a mid-bit edge, locked
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			dec_q <= scfdc_pkg::DEC_OFF;
		end else if (!md0_en_q) begin
			dec_q <= scfdc_pkg::DEC_OFF; // RQ6
		end else begin
			unique case (dec_q)
				scfdc_pkg::DEC_OFF: begin
					dec_q <= scfdc_pkg::DEC_HUNT;
				end
				scfdc_pkg::DEC_HUNT: begin
					// First edge taken as a mid-bit edge
					if (edge_seen)
						dec_q <= scfdc_pkg::DEC_LOCK;
				end
				scfdc_pkg::DEC_LOCK: begin
					// Line gone quiet: lock lost
					if (tm_q == `SCFDC_LOSS)
						dec_q <= scfdc_pkg::DEC_HUNT;
				end
				default: begin
					dec_q <= scfdc_pkg::DEC_OFF;
				end
			endcase
		end
	end

	// Line history and clocks since the accepted edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			line_q <= 1'b0;
			tm_q   <= 4'h0;
		end else begin
			line_q <= line_now;
			if (dec_q == scfdc_pkg::DEC_OFF)
				tm_q <= 4'h0;
			else if (edge_seen && tm_q >= `SCFDC_BLANK)
				tm_q <= 4'h0;
			else if (dec_q == scfdc_pkg::DEC_HUNT && edge_seen)
				tm_q <= 4'h0;
			else if (tm_q != `SCFDC_LOSS)
				tm_q <= tm_q + 4'h1;
		end
	end

	// Edges inside the blanking window are bit boundaries;
	// the next one after it is mid-bit and carries the bit
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bit_stb_q <= 1'b0;
			bit_val_q <= 1'b0;
			bit_ch_q  <= 1'b0;
			ch_q      <= 1'b0;
		end else begin
			bit_stb_q <= 1'b0;
			if (dec_q != scfdc_pkg::DEC_LOCK) begin
				ch_q <= 1'b0;
			end else if (edge_seen && tm_q >= `SCFDC_BLANK) begin
				bit_stb_q <= 1'b1;
				bit_val_q <= line_now;
				bit_ch_q  <= ch_q;
				ch_q      <= !ch_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Output registers
	// ------------------------------------------------------------
	// Sample 4 waits for its partner, then both load together
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			hold4_q <= `SCFDC_WORD_RST;
			out4_q  <= `SCFDC_WORD_RST;
			out5_q  <= `SCFDC_WORD_RST;
		end else begin
			if (s4.sample_valid)
				hold4_q <= s4.sample;
			if (pair_set) begin
				out4_q <= hold4_q;
				out5_q <= s5.sample;
			end
		end
	end

	// ------------------------------------------------------------
	// Sample ready flags
	// ------------------------------------------------------------
	// A read by either core clears; a new pair sets and wins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			flag4_q <= 1'b0;
			flag5_q <= 1'b0;
		end else begin
			if (pair_set)
				flag4_q <= 1'b1; // RQ2 RQ9
			else if (rd_out4)
				flag4_q <= 1'b0;
			if (pair_set)
				flag5_q <= 1'b1; // RQ2 RQ9
			else if (rd_out5)
				flag5_q <= 1'b0; // RQ1
		end
	end

	// ------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------
	// Rate field locked while any decoder is enabled
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			osr_q <= scfdc_pkg::OSR_32;
		end else if (wr_ctrl && !md0_en_q) begin // RQ5
			osr_q <= scfdc_pkg::scfdc_osr_t'(
				reg_wdata[`SCFDC_OSR_HI:`SCFDC_OSR_LO]); // RQ4
		end
	end

	// Enables: processing core writes are dropped
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			md0_en_q <= 1'b0;
			irq_en_q <= 1'b0;
		end else if (wr_ctrl) begin // RQ8
			md0_en_q <= reg_wdata[`SCFDC_DECODER0_ENABLE]; // RQ6
			irq_en_q <= reg_wdata[`SCFDC_IRQEN];
		end
	end

	// ------------------------------------------------------------
	// Interrupt status, mask and line
	// ------------------------------------------------------------
	// Sample event, and overrun when flag 5 was still unread
	always_comb begin
		stat_set = `SCFDC_ST_RST;
		stat_set[`SCFDC_ST_SAMPLE] = pair_set;
		stat_set[`SCFDC_ST_OVRUN]  = pair_set && flag5_q;
		stat_clr = wr_stat ? reg_wdata[`SCFDC_ST_W-1:0] : `SCFDC_ST_RST;
	end

	// Sticky bits, write one to clear, a new event wins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			stat_q <= `SCFDC_ST_RST;
		else
			stat_q <= (stat_q & ~stat_clr) | stat_set;
	end

	// Mask, same layout as status
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			mask_q <= `SCFDC_ST_RST;
		else if (wr_mask)
			mask_q <= reg_wdata[`SCFDC_ST_W-1:0];
	end

	// Level output gated by the pair enable and the mask
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			irq_q <= 1'b0;
		else
			irq_q <= irq_en_q && |(stat_q & mask_q); // RQ3
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Unlisted bits and unmapped offsets read zero
	always_comb begin
		ctrl_rd = `SCFDC_WORD_RST;
		ctrl_rd[`SCFDC_FLAG4] = flag4_q;
		ctrl_rd[`SCFDC_FLAG5] = flag5_q;
		ctrl_rd[`SCFDC_OSR_HI:`SCFDC_OSR_LO] = osr_q;
		ctrl_rd[`SCFDC_DECODER0_ENABLE]  = md0_en_q;
		ctrl_rd[`SCFDC_IRQEN] = irq_en_q;
		rd_mux = `SCFDC_WORD_RST;
		unique case (reg_addr)
			`SCFDC_ADDR_CTRL: rd_mux = ctrl_rd;
			`SCFDC_ADDR_OUT4: rd_mux = out4_q;
			`SCFDC_ADDR_OUT5: rd_mux = out5_q;
			`SCFDC_ADDR_STAT: rd_mux[`SCFDC_ST_W-1:0] = stat_q;
			`SCFDC_ADDR_MASK: rd_mux[`SCFDC_ST_W-1:0] = mask_q;
			default:          rd_mux = `SCFDC_WORD_RST;
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst)
			rdata_q <= `SCFDC_WORD_RST;
		else
			rdata_q <= reg_rd ? rd_mux : `SCFDC_WORD_RST;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata        = rdata_q;
	assign md0_input_forced = forced_q;
	assign md0_diff_mode    = diff_q;
	assign irq              = irq_q;

endmodule

// ===== verification/scfdc_chk.sv
// Port checker for the sinc decoder control block, bound to its top
`timescale 1ns/1ns
`include "scfdc_params.svh"
module scfdc_chk (
	input wire logic                   mclk,
	input wire logic                   nrst,
	input wire logic [7:0]             reg_addr,
	input wire scfdc_pkg::scfdc_word_t reg_wdata,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic                   reg_core,
	input wire scfdc_pkg::scfdc_word_t reg_rdata,
	input wire logic                   md0_pos_pin,
	input wire logic                   md0_neg_pin,
	input wire logic                   pin_output_mode_bit,
	input wire logic                   md0_input_forced,
	input wire logic                   md0_diff_mode,
	input wire logic                   irq
);
	// ------------------------------
	// Shadow of the control word
	// ------------------------------
	logic       decoder0_enable_q;   // Decoder 0 enable
	logic       irqen_q;  // Pair interrupt enable
	logic [1:0] osr_q;    // Rate code
	logic       ctl_wr;   // Supervisory control write
	logic       ctl_rd;   // Control read
	logic       out5_rd;  // Output 5 read
	logic       diff_exp; // Mode ahead of its output flop

	assign ctl_wr   = reg_wr && reg_addr == `SCFDC_ADDR_CTRL
		&& reg_core == `SCFDC_CORE_SUPV;
	assign ctl_rd   = reg_rd && reg_addr == `SCFDC_ADDR_CTRL;
	assign out5_rd  = reg_rd && reg_addr == `SCFDC_ADDR_OUT5;
	assign diff_exp = decoder0_enable_q & pin_output_mode_bit;

	// Follow supervisory writes; rate frozen while enabled
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			decoder0_enable_q  <= 1'h0;
			irqen_q <= 1'h0;
			osr_q   <= 2'h0;
		end else if (ctl_wr) begin
			decoder0_enable_q  <= reg_wdata[`SCFDC_DECODER0_ENABLE];
			irqen_q <= reg_wdata[`SCFDC_IRQEN];
			if (!decoder0_enable_q)
				osr_q <= reg_wdata[`SCFDC_OSR_HI:`SCFDC_OSR_LO];
		end
	end

	// ------------------------------
	// Assertions
	// ------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
	a_flag5_clear: assert property (
		out5_rd ##[1:2] ctl_rd |=> !reg_rdata[`SCFDC_FLAG5])
		else $error("flag 5 not cleared by output read");
	a_flags_paired: assert property (
		ctl_rd ##1 (ctl_rd && reg_rdata[5:4] == 2'h0)
		|=> reg_rdata[`SCFDC_FLAG4] == reg_rdata[`SCFDC_FLAG5])
		else $error("flags 4 and 5 set apart");
	a_irq_gate: assert property (irq |-> $past(irqen_q))
		else $error("interrupt without pair enable");
	a_rate_lock: assert property (
		ctl_rd |=> reg_rdata[7:6] == $past(osr_q))
		else $error("rate field wrong");
	a_enable_core: assert property (
		ctl_rd |=> reg_rdata[`SCFDC_DECODER0_ENABLE] == $past(decoder0_enable_q)
		&& reg_rdata[`SCFDC_IRQEN] == $past(irqen_q))
		else $error("enable bits wrong");
	a_forced_track: assert property (
		md0_input_forced == $past(decoder0_enable_q))
		else $error("forced input not following enable");
	a_diff_track: assert property (
		md0_diff_mode == $past(diff_exp))
		else $error("input mode not following mode bit");

	c_irq: cover property (irq);
	c_poll: cover property (ctl_rd ##1 ctl_rd);
	c_lock: cover property (ctl_wr && decoder0_enable_q && reg_wdata[7:6] != osr_q);
endmodule

bind scfdc_top scfdc_chk scfdc_chk_i (
	.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_core(reg_core),
	.reg_rdata(reg_rdata), .md0_pos_pin(md0_pos_pin),
	.md0_neg_pin(md0_neg_pin), .pin_output_mode_bit(pin_output_mode_bit),
	.md0_input_forced(md0_input_forced), .md0_diff_mode(md0_diff_mode),
	.irq(irq));

// ===== verification/scfdc_mod_src.sv
// Delta-sigma bit-stream source on the decoder 0 Manchester pins
`timescale 1ns/1ns
module scfdc_mod_src #(
	parameter int         HALF  = 4,    // Clocks per half bit
	parameter logic [7:0] LEVEL = 8'h80 // Input level, 80 alternates bits
) (
	input  wire logic mclk,
	input  wire logic run,
	output wire logic pos_pin,
	output wire logic neg_pin
);
	logic [7:0] acc_q; // Integrator
	logic [3:0] ph_q;  // Clock within the bit
	logic [8:0] sum;   // Integrator plus level, carry is the bit

	assign sum = {1'h0, acc_q} + {1'h0, LEVEL};
	// Inverse first, so the mid-bit edge lands on the bit value
	assign pos_pin = run && ((ph_q < 4'(HALF)) ? !sum[8] : sum[8]);
	// Complement for differential use; idle lines stand still
	assign neg_pin = !pos_pin;

	// Step the bit phase, integrate once per bit
	always_ff @(posedge mclk) begin
		if (!run) begin
			acc_q <= 8'h80;
			ph_q  <= 4'h0;
		end else if (ph_q == 4'(2 * HALF - 1)) begin
			acc_q <= sum[7:0];
			ph_q  <= 4'h0;
		end else begin
			ph_q <= ph_q + 4'h1;
		end
	end
endmodule

// ===== verification/sinc_filter_decoder_control_test.sv
// Self-checking bench for the sinc decoder control block
`timescale 1ns/1ns
`include "scfdc_params.svh"
module sinc_filter_decoder_control_test;
	logic                   mclk = 1'h0; // 25 MHz clock
	logic                   nrst;        // Reset, active low
	logic [7:0]             reg_addr;    // Register address
	scfdc_pkg::scfdc_word_t reg_wdata;   // Write data
	logic                   reg_wr;      // Write strobe
	logic                   reg_rd;      // Read strobe
	logic                   reg_core;    // Issuing core
	scfdc_pkg::scfdc_word_t reg_rdata;   // Read data
	logic                   mode_bit;    // Positive pin mode
	logic                   run;         // Modulator running
	logic                   pos;         // Positive pin
	logic                   neg;         // Negative pin
	logic                   forced;      // Input forced
	logic                   diff;        // Differential mode
	logic                   irq;         // Interrupt
	scfdc_pkg::scfdc_word_t d;           // Last word read
	int                     n_errors = 0;
	int                     cmp_count = 0;
	int                     cyc = 0;
	int                     t0;
	int                     t1;

	always #20 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;

	scfdc_mod_src scfdc_mod_src_i (.mclk(mclk), .run(run), .pos_pin(pos),
		.neg_pin(neg));
	scfdc_top scfdc_top_i (
		.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_core(reg_core),
		.reg_rdata(reg_rdata), .md0_pos_pin(pos), .md0_neg_pin(neg),
		.pin_output_mode_bit(mode_bit), .md0_input_forced(forced),
		.md0_diff_mode(diff), .irq(irq));

	// -----------------------------
	// Tasks
	// -----------------------------
	task close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input scfdc_pkg::scfdc_word_t got, input scfdc_pkg::scfdc_word_t e);
		cmp_count++;
		if (got !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, e);
		end
	endtask

	// Compare irq, forced and mode outputs once settled
	task chk_pins(input logic [2:0] e);
		@(negedge mclk);
		chk({13'h0, irq, forced, diff}, {13'h0, e});
		@(posedge mclk);
	endtask

	task wr(input logic [7:0] a, input scfdc_pkg::scfdc_word_t v, input logic c);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_core  <= c;
		reg_wr    <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
		@(posedge mclk);
	endtask

	task rd(input logic [7:0] a, input logic c, output scfdc_pkg::scfdc_word_t v);
		reg_addr <= a;
		reg_core <= c;
		reg_rd   <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(negedge mclk);
		v = reg_rdata;
		@(posedge mclk);
	endtask

	task rchk(input logic [7:0] a, input scfdc_pkg::scfdc_word_t e);
		rd(a, 1'h0, d);
		chk(d, e);
	endtask

	// Back-to-back control reads until a ready flag shows
	task pollf(output scfdc_pkg::scfdc_word_t v);
		int i;
		reg_addr <= `SCFDC_ADDR_CTRL;
		reg_core <= 1'h0;
		reg_rd   <= 1'h1;
		for (i = 0; i < 2000 && reg_rdata[5:4] === 2'h0; i++) begin
			@(posedge mclk);
			@(negedge mclk);
		end
		v = reg_rdata;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(posedge mclk);
		if (i == 2000) begin
			chk(v, 16'h0030);
			close_out;
		end
	endtask

	task wirq(input logic lv, input int n);
		int i;
		@(negedge mclk);
		for (i = 0; i < n && irq !== lv; i++)
			@(negedge mclk);
		@(posedge mclk);
		if (i == n) begin
			chk(16'(irq), 16'(lv));
			close_out;
		end
	endtask

	task clr;
		wr(`SCFDC_ADDR_STAT, 16'h0003, 1'h0);
		rd(`SCFDC_ADDR_OUT4, 1'h0, d);
		rd(`SCFDC_ADDR_OUT5, 1'h0, d);
	endtask

	// -----------------------------
	// Test sequence
	// -----------------------------
	initial begin
		nrst      = 1'h0;
		reg_addr  = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr    = 1'h0;
		reg_rd    = 1'h0;
		reg_core  = 1'h0;
		mode_bit  = 1'h0;
		run       = 1'h0;
		repeat (2) @(posedge mclk);
		nrst <= 1'h1;
		@(posedge mclk);
		rchk(`SCFDC_ADDR_CTRL, 16'h0000);
		rchk(`SCFDC_ADDR_STAT, 16'h0000);
		rchk(`SCFDC_ADDR_MASK, 16'h0000);
		rchk(8'h3C, 16'h0000);
		$display("reset values done");
		wr(`SCFDC_ADDR_CTRL, 16'h4100, 1'h1);
		rchk(`SCFDC_ADDR_CTRL, 16'h0000);
		wr(`SCFDC_ADDR_CTRL, 16'h00C0, 1'h0);
		rchk(`SCFDC_ADDR_CTRL, 16'h00C0);
		wr(`SCFDC_ADDR_CTRL, 16'h0100, 1'h0);
		chk_pins(3'h2);
		wr(`SCFDC_ADDR_CTRL, 16'h01C0, 1'h0);
		rchk(`SCFDC_ADDR_CTRL, 16'h0100);
		mode_bit <= 1'h1;
		@(posedge mclk);
		chk_pins(3'h3);
		wr(`SCFDC_ADDR_CTRL, 16'h0000, 1'h0);
		chk_pins(3'h0);
		$display("control access done");
		wr(`SCFDC_ADDR_CTRL, 16'h4100, 1'h0);
		run <= 1'h1;
		pollf(d);
		chk(d & 16'h0030, 16'h0030);
		rchk(`SCFDC_ADDR_STAT, 16'h0001);
		chk_pins(3'h3);
		wr(`SCFDC_ADDR_MASK, 16'h0001, 1'h0);
		wirq(1'h1, 4);
		wr(`SCFDC_ADDR_CTRL, 16'h0100, 1'h0);
		wirq(1'h0, 4);
		rd(`SCFDC_ADDR_OUT5, 1'h1, d);
		rchk(`SCFDC_ADDR_CTRL, 16'h0110);
		rd(`SCFDC_ADDR_OUT4, 1'h0, d);
		rchk(`SCFDC_ADDR_CTRL, 16'h0100);
		wr(`SCFDC_ADDR_STAT, 16'h0003, 1'h0);
		rchk(`SCFDC_ADDR_STAT, 16'h0000);
		$display("flags and interrupt done");
		// Sample spacing for every rate code, past the settling samples
		for (int r = 0; r < 4; r++) begin
			wr(`SCFDC_ADDR_CTRL, 16'h0000, 1'h0);
			run <= 1'h0;
			clr;
			wr(`SCFDC_ADDR_CTRL, {8'h41, 2'(r), 6'h00}, 1'h0);
			run <= 1'h1;
			wirq(1'h1, 9000);
			clr;
			wirq(1'h1, 9000);
			t0 = cyc;
			clr;
			wirq(1'h1, 9000);
			t1 = cyc;
			chk(16'(t1 - t0), 16'h0200 << r);
			$display("rate code %0d done", r);
		end
		close_out;
	end
endmodule
